// ### design/msg_parser.sv
/*
  parses incoming message bytes: extended messages (sync request, extended
  identify) and message reject.
  assumes: bytes of one message arrive in order, no other message interleaved.
*/
`timescale 1ns/100ps
module msg_parser
  import sdtr_pkg::*;
(
  input  wire logic  i_clk_sys,
  input  wire logic  i_rstn,
  input  wire logic  i_ce,
  input  wire logic  i_abort,
  msg_rx_if.parser   rx
);
  logic [8:0] cnt_q;
  logic [7:0] len_q;
  logic [7:0] code_q;
  logic [7:0] arg_q;

  // ==========================================================
  // decode
  wire       at_first = (cnt_q == 9'h000);
  wire [8:0] last_cnt = (len_q == 8'h00) ? 9'h101 : ({1'b0, len_q} + 9'h001);
  wire       in_args  = (cnt_q >= 9'h002);
  wire       last_arg = rx.rx_valid && in_args && (cnt_q == last_cnt);
  wire       is_sdtr  = (code_q == CODE_SDTR) && (len_q == LEN_SDTR);
  wire       is_xid   = (code_q == CODE_XID) && (len_q == LEN_XID);

  // ==========================================================
  // byte counter
  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      cnt_q  <= 9'h000;
      len_q  <= 8'h00;
      code_q <= 8'h00;
      arg_q  <= 8'h00;
    end else if (i_ce) begin
      if (i_abort || last_arg) begin
        cnt_q <= 9'h000;
      end else if (rx.rx_valid) begin
        if (at_first) begin
          cnt_q <= (rx.rx_byte == MSG_EXT) ? 9'h001 : 9'h000;
        end else begin
          cnt_q <= cnt_q + 9'h001;
        end
        if (cnt_q == 9'h001) len_q <= rx.rx_byte;
        if (cnt_q == 9'h002) code_q <= rx.rx_byte;
        if (cnt_q == 9'h003) arg_q <= rx.rx_byte;
      end
    end
  end

  // ==========================================================
  // result strobes, one cycle each
  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      rx.sdtr_stb <= 1'b0;
      rx.xid_stb  <= 1'b0;
      rx.rej_stb  <= 1'b0;
      rx.sdtr_per <= 8'h00;
      rx.sdtr_ofs <= 8'h00;
      rx.xid_sub  <= 8'h00;
    end else if (i_ce) begin
      rx.sdtr_stb <= last_arg && is_sdtr && !i_abort;
      rx.xid_stb  <= last_arg && is_xid && !i_abort;
      rx.rej_stb  <= rx.rx_valid && at_first && (rx.rx_byte == MSG_REJECT) && !i_abort;
      if (last_arg && is_sdtr) begin
        rx.sdtr_per <= arg_q;
        rx.sdtr_ofs <= rx.rx_byte;
      end
      if (last_arg && is_xid) rx.xid_sub <= rx.rx_byte;
    end
  end

  chk_sdtr_five_bytes : assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    (i_ce && last_arg && is_sdtr && !i_abort) |-> (cnt_q == 9'h004))
    else $error("sync request strobe not on its fifth byte");
endmodule

// ### design/msg_rx_if.sv
/*
  carrier between the controller and its incoming-message parser.
  assumes: one byte per rx_valid pulse, results are one-cycle strobes.
*/
`timescale 1ns/100ps
interface msg_rx_if;
  logic [7:0] rx_byte;
  logic       rx_valid;
  logic       sdtr_stb;
  logic [7:0] sdtr_per;
  logic [7:0] sdtr_ofs;
  logic       xid_stb;
  logic [7:0] xid_sub;
  logic       rej_stb;
  modport parser (input rx_byte, rx_valid, output sdtr_stb, sdtr_per, sdtr_ofs, xid_stb, xid_sub, rej_stb);
  modport ctrl   (output rx_byte, rx_valid, input sdtr_stb, sdtr_per, sdtr_ofs, xid_stb, xid_sub, rej_stb);
endinterface

// ### design/sdtr_ctrl.sv
/*
  initiator-side synchronous transfer negotiation controller: asserts
  attention, sends sync requests and extended identify, answers a target's
  sync request, keeps one agreement per peer id and applies it at data start.
  assumes: bus phase logic outside reports selection, message-out phase,
  bus free, resets and delivers message bytes; registers on a plain port.
*/
// The register offsets and the address-and-strobe port were decided locally.
`timescale 1ns/100ps
module sdtr_ctrl
  import sdtr_pkg::*;
#(
  parameter int N_ID = 8,
  parameter int ID_W = 3
) (
  input  wire logic            i_clk_sys,
  input  wire logic            i_rstn,
  input  wire logic            i_ce,
  input  wire logic [3:0]      i_addr,
  input  wire logic [31:0]     i_wdata,
  input  wire logic            i_wr,
  input  wire logic            i_rd,
  output logic [31:0]          o_rdata,
  input  wire logic            i_sel_done,
  input  wire logic            i_sel_both_ids,
  input  wire logic [ID_W-1:0] i_peer_id,
  input  wire logic            i_bus_free,
  input  wire logic            i_hard_rst,
  input  wire logic            i_dev_rst_sent,
  input  wire logic            i_msg_out,
  input  wire logic            i_msg_ready,
  input  wire logic [7:0]      i_rx_byte,
  input  wire logic            i_rx_valid,
  input  wire logic            i_data_start,
  output logic                 o_atn,
  output logic [7:0]           o_msg_byte,
  output logic                 o_msg_valid,
  output logic [7:0]           o_sync_period,
  output logic [7:0]           o_sync_offset,
  output logic [7:0]           o_req_gap_cyc,
  output logic                 o_sync_en,
  output logic                 o_unlimited
);
  msg_rx_if rx ();

  neg_state_e      state_q;
  logic [2:0]      idx_q;
  logic            kind_xid_q;
  logic            reply_q;
  logic [7:0]      tx_per_q;
  logic [7:0]      tx_ofs_q;
  logic [16:0]     cfg_q;
  logic [7:0]      sub_q;
  logic [7:0]      rx_sub_q;
  logic            neg_req_q;
  logic            xid_req_q;
  logic [ID_W-1:0] peer_q;
  logic            sel_ok_q;
  logic [7:0]      tab_per_q [N_ID];
  logic [7:0]      tab_ofs_q [N_ID];
  logic [N_ID-1:0] talked_q;

  assign rx.rx_byte  = i_rx_byte;
  assign rx.rx_valid = i_rx_valid;

  msg_parser msg_parser_inst (
    .i_clk_sys (i_clk_sys),
    .i_rstn    (i_rstn),
    .i_ce      (i_ce),
    .i_abort   (i_bus_free),
    .rx        (rx.parser)
  );

  // ==========================================================
  // configuration fields and decode
  wire [7:0] my_ofs    = cfg_q[CFG_OFS_LSB +: 8];
  wire [7:0] my_per    = cfg_q[CFG_PER_LSB +: 8];
  wire       my_unlim  = cfg_q[CFG_UNLIM_BIT];
  wire       cur_talk  = talked_q[peer_q];
  wire [7:0] cur_per   = tab_per_q[peer_q];
  wire [7:0] cur_ofs   = tab_ofs_q[peer_q];
  wire       wr_ctrl   = i_wr && (i_addr == ADDR_CTRL);
  wire       start_neg = sel_ok_q && (!cur_talk || neg_req_q);
  wire       start_xid = sel_ok_q && xid_req_q && !start_neg;
  wire       beat      = o_msg_valid && i_msg_ready;
  wire       last_idx  = kind_xid_q ? (idx_q == XID_LAST) : (idx_q == SDTR_LAST);
  wire       send_done = (state_q == ST_SEND) && beat && last_idx;

  // target-started request: answer that is never beyond what it proposed
  wire [7:0] their_ofs = rx.sdtr_ofs;
  wire [7:0] their_per = rx.sdtr_per;
  wire [7:0] rep_per   = (my_per > their_per) ? my_per : their_per;
  wire       their_unl = (their_ofs == OFS_UNLIM);
  wire [7:0] rep_ofs_f = (my_ofs < their_ofs) ? my_ofs : their_ofs;
  wire [7:0] rep_ofs   = their_unl ? (my_unlim ? OFS_UNLIM : OFS_ASYNC) : rep_ofs_f;
  wire       tgt_req   = rx.sdtr_stb && (state_q != ST_WAIT) && sel_ok_q;

  // target answer to our request
  wire       rsp_fit   = (rx.sdtr_ofs <= tx_ofs_q) && (rx.sdtr_per >= tx_per_q);
  wire       wait_end  = (state_q == ST_WAIT) && (rx.sdtr_stb || rx.rej_stb);
  wire       adopt_en  = wait_end || (send_done && reply_q && !kind_xid_q);
  wire [7:0] adopt_ofs = !wait_end ? tx_ofs_q :
                         (rx.rej_stb || !rsp_fit) ? OFS_ASYNC : rx.sdtr_ofs;
  wire [7:0] adopt_per = !wait_end ? tx_per_q : (rx.rej_stb || !rsp_fit) ? 8'h00 : rx.sdtr_per;

  // period in 4 ns units to least cycles between req edges, rounded up
  wire [11:0] per_ns   = 12'(cur_per) * 12'(PERIOD_UNIT_NS);
  wire [11:0] gap_cyc  = (per_ns + 12'(CLK_PERIOD_NS - 1)) / 12'(CLK_PERIOD_NS);

  function automatic logic [7:0] msg_rom(input logic xid, input logic [2:0] i);
    logic [7:0] b;
    b = MSG_EXT;
    unique case (i)
      3'h1:    b = xid ? LEN_XID : LEN_SDTR;
      3'h2:    b = xid ? CODE_XID : CODE_SDTR;
      3'h3:    b = xid ? sub_q : tx_per_q;
      3'h4:    b = tx_ofs_q;
      default: b = MSG_EXT;
    endcase
    return b;
  endfunction

  // ==========================================================
  // registers
  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      cfg_q     <= CFG_RST;
      sub_q     <= SUB_RST;
      neg_req_q <= 1'b0;
      xid_req_q <= 1'b0;
      rx_sub_q  <= 8'h00;
    end else if (i_ce) begin
      if (i_wr && i_addr == ADDR_CFG) cfg_q <= i_wdata[16:0];
      if (i_wr && i_addr == ADDR_SUB) sub_q <= i_wdata[7:0];
      // a new request wins over the clear of the one being started
      if (wr_ctrl && i_wdata[CTRL_NEG_BIT]) neg_req_q <= 1'b1;
      else if (state_q == ST_IDLE && start_neg && !tgt_req && !i_bus_free && !i_hard_rst) neg_req_q <= 1'b0;
      if (wr_ctrl && i_wdata[CTRL_XID_BIT]) xid_req_q <= 1'b1;
      else if (state_q == ST_IDLE && start_xid && !tgt_req && !i_bus_free && !i_hard_rst) xid_req_q <= 1'b0;
      if (rx.xid_stb) rx_sub_q <= rx.xid_sub;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      o_rdata <= 32'h0000_0000;
    end else if (i_ce) begin
      o_rdata <= 32'h0000_0000;
      if (i_rd) begin
        unique case (i_addr)
          ADDR_CTRL:  o_rdata <= {30'h0000_0000, xid_req_q, neg_req_q};
          ADDR_CFG:   o_rdata <= {15'h0000, cfg_q};
          ADDR_SUB:   o_rdata <= {16'h0000, rx_sub_q, sub_q};
          ADDR_STAT:  o_rdata <= {24'h0000_00, state_q, cur_talk, sel_ok_q, 1'b0, 3'(peer_q)};
          ADDR_AGREE: o_rdata <= {16'h0000, cur_per, cur_ofs};
          default:    o_rdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ==========================================================
  // selection tracking
  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      peer_q   <= '0;
      sel_ok_q <= 1'b0;
    end else if (i_ce) begin
      if (i_sel_done) begin
        peer_q   <= i_peer_id;
        sel_ok_q <= i_sel_both_ids;
      end else if (i_bus_free || i_hard_rst) begin
        sel_ok_q <= 1'b0;
      end
    end
  end

  // ==========================================================
  // per-peer agreement table
  for (genvar g = 0; g < N_ID; g++) begin : g_tab
    wire hit = (peer_q == ID_W'(g));
    always_ff @(posedge i_clk_sys) begin
      if (!i_rstn) begin
        tab_per_q[g] <= 8'h00;
        tab_ofs_q[g] <= OFS_ASYNC;
        talked_q[g]  <= 1'b0;
      end else if (i_ce) begin
        if (i_hard_rst || (i_dev_rst_sent && hit)) begin
          tab_per_q[g] <= 8'h00;
          tab_ofs_q[g] <= OFS_ASYNC;
          talked_q[g]  <= 1'b0;
        end else if (adopt_en && hit) begin
          tab_per_q[g] <= adopt_per;
          tab_ofs_q[g] <= adopt_ofs;
          talked_q[g]  <= 1'b1;
        end
      end
    end
  end

  // ==========================================================
  // negotiation sequencer
  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      state_q     <= ST_IDLE;
      idx_q       <= 3'h0;
      kind_xid_q  <= 1'b0;
      reply_q     <= 1'b0;
      tx_per_q    <= 8'h00;
      tx_ofs_q    <= 8'h00;
      o_atn       <= 1'b0;
      o_msg_valid <= 1'b0;
      o_msg_byte  <= 8'h00;
    end else if (i_ce) begin
      if (i_bus_free || i_hard_rst) begin
        state_q     <= ST_IDLE;
        o_atn       <= 1'b0;
        o_msg_valid <= 1'b0;
      end else begin
        unique case (state_q)
          ST_IDLE: begin
            if (tgt_req) begin
              reply_q    <= 1'b1;
              kind_xid_q <= 1'b0;
              tx_per_q   <= rep_per;
              tx_ofs_q   <= rep_ofs;
              o_atn      <= 1'b1;
              state_q    <= ST_ATN;
            end else if (start_neg || start_xid) begin
              reply_q    <= 1'b0;
              kind_xid_q <= start_xid;
              tx_per_q   <= my_per;
              tx_ofs_q   <= my_ofs;
              o_atn      <= 1'b1;
              state_q    <= ST_ATN;
            end
          end
          ST_ATN: begin
            // message bytes only once the target has entered message-out
            if (i_msg_out) begin
              idx_q       <= 3'h0;
              o_msg_byte  <= msg_rom(kind_xid_q, 3'h0);
              o_msg_valid <= 1'b1;
              state_q     <= ST_SEND;
            end
          end
          ST_SEND: begin
            if (beat) begin
              idx_q      <= idx_q + 3'h1;
              o_msg_byte <= msg_rom(kind_xid_q, idx_q + 3'h1);
              if (last_idx) begin
                o_msg_valid <= 1'b0;
                o_atn       <= 1'b0;
                state_q     <= (kind_xid_q || reply_q) ? ST_IDLE : ST_WAIT;
              end
            end
          end
          ST_WAIT: begin
            if (wait_end) state_q <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // ==========================================================
  // agreement applied when a data phase with the peer begins
  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      o_sync_period <= 8'h00;
      o_sync_offset <= OFS_ASYNC;
      o_req_gap_cyc <= 8'h00;
      o_sync_en     <= 1'b0;
      o_unlimited   <= 1'b0;
    end else if (i_ce && i_data_start) begin
      o_sync_period <= cur_per;
      o_sync_offset <= cur_ofs;
      o_req_gap_cyc <= gap_cyc[7:0];
      o_sync_en     <= (cur_ofs != OFS_ASYNC);
      o_unlimited   <= (cur_ofs == OFS_UNLIM);
    end
  end

  // ==========================================================
  // checks
  chk_reject_goes_async : assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    (i_ce && state_q == ST_WAIT && rx.rej_stb && !i_hard_rst && !i_dev_rst_sent && !i_bus_free)
      |=> (tab_ofs_q[$past(peer_q)] == OFS_ASYNC) && talked_q[$past(peer_q)])
    else $error("reject did not give asynchronous agreement");

  chk_fit_answer_adopt : assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    (i_ce && state_q == ST_WAIT && rx.sdtr_stb && rsp_fit && !i_hard_rst && !i_dev_rst_sent && !i_bus_free)
      |=> (tab_ofs_q[$past(peer_q)] == $past(rx.sdtr_ofs)) && (tab_per_q[$past(peer_q)] == $past(rx.sdtr_per)))
    else $error("fitting target answer not adopted");

  chk_hard_reset_async : assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    (i_ce && i_hard_rst) |=> (talked_q == '0) && (tab_ofs_q[0] == OFS_ASYNC) && (state_q == ST_IDLE))
    else $error("hard reset left an agreement standing");

  chk_attention_needs_sel : assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    $rose(o_atn) |-> $past(sel_ok_q))
    else $error("attention raised without a full selection");

  chk_atn_before_bytes : assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    $rose(o_msg_valid) |-> o_atn && $past(o_atn) && (o_msg_byte == MSG_EXT))
    else $error("message bytes started without attention");

  chk_request_layout : assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    (o_msg_valid && !kind_xid_q && idx_q == 3'h1) |-> ((o_msg_byte == LEN_SDTR) and
      ((i_ce && i_msg_ready && !i_bus_free && !i_hard_rst) |=> (o_msg_byte == CODE_SDTR))))
    else $error("sync request header bytes wrong");

  chk_xid_layout : assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    (o_msg_valid && kind_xid_q && idx_q == XID_LAST) |-> (o_msg_byte == sub_q))
    else $error("extended identify sub-unit byte wrong");

  chk_reply_within : assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    (i_ce && state_q == ST_IDLE && tgt_req && !i_bus_free && !i_hard_rst)
      |=> reply_q && (tx_per_q >= $past(their_per)) && ((tx_ofs_q <= $past(their_ofs)) || tx_ofs_q == OFS_ASYNC))
    else $error("reply goes beyond the target proposal");

  chk_keep_agreement : assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    (!i_hard_rst && !i_dev_rst_sent && !adopt_en) |=> (tab_ofs_q[$past(peer_q)] == $past(cur_ofs)))
    else $error("agreement changed without reset or renegotiation");
endmodule

// ### design/sdtr_pkg.sv
/*
  constants, register map and state encoding for the synchronous transfer
  negotiation controller (initiator side).
  assumes: a 25 MHz system clock; message bytes arrive already deserialised.
*/
package sdtr_pkg;
  // ==========================================================
  // timing
  localparam int CLK_PERIOD_NS  = 40;
  localparam int PERIOD_UNIT_NS = 4;
  // ==========================================================
  // message bytes
  localparam logic [7:0] MSG_EXT    = 8'h01;
  localparam logic [7:0] MSG_REJECT = 8'h07;
  localparam logic [7:0] LEN_SDTR   = 8'h03;
  localparam logic [7:0] CODE_SDTR  = 8'h01;
  localparam logic [7:0] LEN_XID    = 8'h02;
  localparam logic [7:0] CODE_XID   = 8'h02;
  localparam logic [7:0] OFS_ASYNC  = 8'h00;
  localparam logic [7:0] OFS_UNLIM  = 8'hFF;
  localparam logic [2:0] SDTR_LAST  = 3'h4;
  localparam logic [2:0] XID_LAST   = 3'h3;
  // ==========================================================
  // register map (word offsets) and fields
  localparam logic [3:0] ADDR_CTRL  = 4'h0;
  localparam logic [3:0] ADDR_CFG   = 4'h1;
  localparam logic [3:0] ADDR_SUB   = 4'h2;
  localparam logic [3:0] ADDR_STAT  = 4'h3;
  localparam logic [3:0] ADDR_AGREE = 4'h4;
  localparam int CTRL_NEG_BIT  = 0;
  localparam int CTRL_XID_BIT  = 1;
  localparam int CFG_OFS_LSB   = 0;
  localparam int CFG_PER_LSB   = 8;
  localparam int CFG_UNLIM_BIT = 16;
  localparam logic [16:0] CFG_RST = 17'h0_3208;
  localparam logic [7:0]  SUB_RST = 8'h00;
  // ==========================================================
  // negotiation sequencer
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ATN  = 2'b01,
    ST_SEND = 2'b10,
    ST_WAIT = 2'b11
  } neg_state_e;
endpackage

// ### test/sdtr_tgt_model.sv
/*
  target model: takes message-out bytes, answers on message-in.
  assumes: it faces the message pins of sdtr_ctrl.
*/
`timescale 1ns/100ps
module sdtr_tgt_model (
  input  wire logic       i_clk_sys,
  input  wire logic       i_rstn,
  input  wire logic       i_atn,
  input  wire logic [7:0] i_byte,
  input  wire logic       i_valid,
  input  wire logic       i_rej,
  input  wire logic       i_slow,
  input  wire logic [7:0] i_ofs,
  input  wire logic [7:0] i_per,
  output logic            o_msg_out = 0,
  output logic            o_ready = 0,
  output logic [7:0]      o_rx_byte = 0,
  output logic            o_rx_valid = 0
);
  // ==========================================
  // capture and reply
  logic [7:0] cap [0:7];
  logic [7:0] txq [$];
  int         cnt = 0;
  int         msgs = 0;
  bit         own = 0;
  task automatic propose(input logic [7:0] per, input logic [7:0] ofs);
    #1;
    own = 1;
    txq = {8'h01, 8'h03, 8'h01, per, ofs};
  endtask
  task automatic send_sub(input logic [7:0] sub);
    #1;
    txq = {8'h01, 8'h02, 8'h02, sub};
  endtask
  always @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      {o_msg_out, o_ready, o_rx_valid} <= '0;
      cnt = 0;
    end else begin
      o_msg_out <= i_atn;
      // slow mode drops ready every other cycle
      o_ready <= !i_slow || !o_ready;
      if (i_valid && o_ready) begin
        cap[cnt] = i_byte;
        cnt++;
        if (cnt >= 3 && cnt == cap[1] + 2) begin
          cnt = 0;
          msgs++;
          if (cap[2] == 8'h01 && !own) begin
            if (i_rej) txq = {8'h07};
            else txq = {8'h01, 8'h03, 8'h01, i_per, i_ofs};
          end
          own = 0;
        end
      end
      if (txq.size() > 0 && !o_msg_out) begin
        o_rx_valid <= 1;
        o_rx_byte <= txq.pop_front();
      end else begin
        o_rx_valid <= 0;
        // released line: alternate the complement of the last byte with the byte itself
        o_rx_byte <= ~o_rx_byte;
      end
    end
  end
endmodule

// ### test/tb_sdtr_ctrl.sv
/*
  bench for sdtr_ctrl with the target model on its message pins.
  assumes: register map and timing of sdtr_pkg.
*/
`timescale 1ns/100ps
module tb_sdtr_ctrl;
  import sdtr_pkg::*;
  logic        clk = 0, rstn = 0, wr_s = 0, rd_s = 0, sel_s = 0, both = 0;
  logic        hrst = 0, drst = 0, dstart = 0, rej = 0, slow = 0, ce = 1, bfree = 0;
  logic [3:0]  addr = 0;
  logic [31:0] wdata = 0, rdata;
  logic [2:0]  pid = 0;
  logic [7:0]  aofs = 0, aper = 0, mb, per, ofs, gap, rxb;
  logic        atn, mv, en, unl, mo, rdy, rxv;
  int          mismatches = 0, num_checks = 0, b;
  sdtr_ctrl sdtr_ctrl_inst (.i_clk_sys(clk), .i_rstn(rstn), .i_ce(ce), .i_addr(addr),
    .i_wdata(wdata), .i_wr(wr_s), .i_rd(rd_s), .o_rdata(rdata), .i_sel_done(sel_s),
    .i_sel_both_ids(both), .i_peer_id(pid), .i_bus_free(bfree), .i_hard_rst(hrst),
    .i_dev_rst_sent(drst), .i_msg_out(mo), .i_msg_ready(rdy), .i_rx_byte(rxb), .i_rx_valid(rxv),
    .i_data_start(dstart), .o_atn(atn), .o_msg_byte(mb), .o_msg_valid(mv), .o_sync_period(per),
    .o_sync_offset(ofs), .o_req_gap_cyc(gap), .o_sync_en(en), .o_unlimited(unl));
  sdtr_tgt_model sdtr_tgt_model_inst (.i_clk_sys(clk), .i_rstn(rstn), .i_atn(atn), .i_byte(mb),
    .i_valid(mv), .i_rej(rej), .i_slow(slow), .i_ofs(aofs), .i_per(aper), .o_msg_out(mo),
    .o_ready(rdy), .o_rx_byte(rxb), .o_rx_valid(rxv));
  initial forever #20 clk = ~clk;
  // ==========================================
  // helpers
  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      mismatches++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  task wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    {addr, wdata, wr_s} <= {a, d, 1'b1};
    @(posedge clk);
    wr_s <= 0;
  endtask
  task rd(input logic [3:0] a, input logic [31:0] e);
    @(posedge clk);
    {addr, rd_s} <= {a, 1'b1};
    @(posedge clk);
    rd_s <= 0;
    #1;
    chk("rdata", rdata, e);
  endtask
  task sel(input logic [2:0] p, input logic bo);
    b = sdtr_tgt_model_inst.msgs;
    @(posedge clk);
    {pid, both, sel_s} <= {p, bo, 1'b1};
    @(posedge clk);
    sel_s <= 0;
  endtask
  task wmsg;
    for (int i = 0; i < 300 && sdtr_tgt_model_inst.msgs == b; i++) @(posedge clk);
    chk("messages", sdtr_tgt_model_inst.msgs, b + 1);
    repeat (12) @(posedge clk);
  endtask
  task capb(input logic [39:0] e, input int n);
    for (int i = 0; i < n; i++) chk("byte", sdtr_tgt_model_inst.cap[i], e[8*(n-1-i)+:8]);
  endtask
  task noatn;
    logic s;
    s = 0;
    repeat (12) begin
      @(posedge clk);
      #1;
      s = s | atn;
    end
    chk("atn", s, 0);
  endtask
  task dcheck(input logic [7:0] o, input logic [7:0] p, input logic [7:0] g, input logic e, input logic u);
    @(posedge clk);
    dstart <= 1;
    @(posedge clk);
    dstart <= 0;
    @(posedge clk);
    #1;
    chk("agreement", {ofs, per, gap, 6'h0, en, unl}, {o, p, g, 6'h0, e, u});
  endtask
  // ==========================================
  // scenarios
  task t_reset;
    rd(ADDR_CFG, 32'(CFG_RST));
    rd(ADDR_AGREE, 32'h0000_0000);
    rd(4'hF, 32'h0000_0000);
    chk("sync_en", en, 0);
  endtask
  task t_first;
    sel(3'h1, 0);
    noatn;
    {aofs, aper, slow} <= {8'h04, 8'h40, 1'b1};
    sel(3'h1, 1);
    wmsg;
    capb(40'h01_0301_3208, 5);
    dcheck(8'h04, 8'h40, 8'h07, 1, 0);
    rd(ADDR_AGREE, 32'h0000_4004);
    sel(3'h1, 1);
    noatn;
  endtask
  task t_reject;
    rej <= 1;
    sel(3'h2, 1);
    wmsg;
    dcheck(8'h00, 8'h00, 8'h00, 0, 0);
    rej <= 0;
    sel(3'h1, 1);
    dcheck(8'h04, 8'h40, 8'h07, 1, 0);
  endtask
  task t_unlim;
    sel(3'h1, 1);
    sdtr_tgt_model_inst.propose(8'h20, 8'hFF);
    wmsg;
    capb(40'h01_0301_3200, 5);
    dcheck(8'h00, 8'h32, 8'h05, 0, 0);
    sel(3'h1, 1);
    sdtr_tgt_model_inst.propose(8'h40, 8'h10);
    wmsg;
    capb(40'h01_0301_4008, 5);
    dcheck(8'h08, 8'h40, 8'h07, 1, 0);
    wr(ADDR_CFG, 32'h0001_3208);
    sel(3'h1, 1);
    sdtr_tgt_model_inst.propose(8'h20, 8'hFF);
    wmsg;
    capb(40'h01_0301_32FF, 5);
    dcheck(8'hFF, 8'h32, 8'h05, 1, 1);
  endtask
  task t_resets;
    @(posedge clk);
    drst <= 1;
    @(posedge clk);
    drst <= 0;
    dcheck(8'h00, 8'h00, 8'h00, 0, 0);
    aofs <= 8'h00;
    sel(3'h1, 1);
    wmsg;
    dcheck(8'h00, 8'h40, 8'h07, 0, 0);
    @(posedge clk);
    hrst <= 1;
    @(posedge clk);
    hrst <= 0;
    dcheck(8'h00, 8'h00, 8'h00, 0, 0);
    sel(3'h2, 1);
    wmsg;
  endtask
  task t_xid;
    slow <= 0;
    wr(ADDR_SUB, 32'h0000_005A);
    wr(ADDR_CTRL, 32'h0000_0002);
    sel(3'h2, 1);
    wmsg;
    capb(40'h00_0102_025A, 4);
    sdtr_tgt_model_inst.send_sub(8'hA5);
    repeat (8) @(posedge clk);
    rd(ADDR_SUB, 32'h0000_A55A);
  endtask
  task t_abort;
    sel(3'h3, 1);
    bfree <= 1;
    @(posedge clk);
    bfree <= 0;
    noatn;
    rd(ADDR_STAT, 32'h0000_0003);
    wr(ADDR_CTRL, 32'h0000_0001);
    rd(ADDR_CTRL, 32'h0000_0001);
    @(posedge clk);
    ce <= 0;
    wr(ADDR_CFG, 32'h0000_0000);
    ce <= 1;
    rd(ADDR_CFG, 32'h0001_3208);
  endtask
  task print_verdict;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge clk);
    rstn <= 1;
    t_reset;
    t_first;
    t_reject;
    t_unlim;
    t_resets;
    t_xid;
    t_abort;
    print_verdict;
  end
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    print_verdict;
  end
endmodule
